// file: src/seb_pkg.sv
// constants and state type of the serial eeprom bus slave
package seb_pkg;

  // memory geometry
  localparam int ADDR_W     = 11;
  localparam int PAGE_W     = 4;
  localparam int BLK_W      = 3;
  localparam int BYTE_W     = 8;

  // control byte layout: type code in the top nibble, read flag in bit 0
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam int         CODE_LSB  = 4;
  localparam int         BLK_LSB   = 1;
  localparam int         RW_BIT    = 0;

  // bit counter values within one nine-clock byte slot
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ACK   = 4'h8;
  localparam logic [3:0] CNT_END   = 4'h9;

  // internally timed write cycle: longest time, rounded down
  localparam int CLK_PERIOD_NS = 100;
  localparam int TWR_MS        = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TWR_CYC       = TWR_MS * NS_PER_MS / CLK_PERIOD_NS;

  // bus transaction phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_WADDR,
    ST_WDATA,
    ST_READ,
    ST_IGNORE
  } seb_state_e;

endpackage : seb_pkg

// file: src/seb_slave.sv
// two-wire serial eeprom slave: bus conditions, page buffer, write timer, reads
//
// How it works
// - bus idle only while data and clock both sit high.
// - data falling with clock high is a START, seen anywhere.
// - data rising with clock high is a STOP, ending every operation.
// - data changes only while clock low; one bit per clock pulse.
// - extra write bytes overwrite oldest; only the last sixteen survive.
// - every byte addressed to us outside programming gets an acknowledge on the ninth clock.
// - acknowledge holds data low across the whole ninth clock high time.
// - master nack ends a read; slave releases data for the STOP.
// - control byte acknowledged only when its type code equals 1010.
// - three block select bits form the top of the 11-bit address.
// - control byte bit zero picks read (one) or write (zero).
// - write: word address byte follows control byte, loads the pointer.
// - STOP after an acknowledged data byte starts the timed programming.
// - page buffer holds up to sixteen bytes until the STOP.
// - each data byte bumps only the low four pointer bits.
// - no acknowledge at all while programming is under way.
// - write protect high blocks every array write.
// - pointer stays one past the last accessed word.
// - read control byte: acknowledge, send eight bits, stop on nack.
// - random read keeps the low eight pointer bits set by the aborted write.
// - master acknowledge asks for the next sequential byte.
// - read pointer counts by one across the whole array.
//
// Implementation choices: the address-and-strobe array port.
`timescale 1ns/1ps
module seb_slave #(
  parameter int TWR_CYCLES = seb_pkg::TWR_CYC,
  parameter int ADDR_W     = seb_pkg::ADDR_W,
  parameter int PAGE_W     = seb_pkg::PAGE_W
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic              wp_in,
  output logic [ADDR_W-1:0]      mem_raddr,
  input  wire logic [7:0]        mem_rdata,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_waddr,
  output logic [7:0]             mem_wdata,
  output logic                   prog_busy
);

  localparam int PAGE_N = 2 ** PAGE_W;
  localparam int HI_W   = ADDR_W - PAGE_W;
  localparam int TMR_W  = $clog2(TWR_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(TWR_CYCLES - 1);

  // type code check, shared by the decoder and its checks
  function automatic logic ctrl_match(input logic [7:0] b);
    ctrl_match = (b[7 -: 4] == seb_pkg::CTRL_CODE);
  endfunction : ctrl_match

  logic                     scl_m;
  logic                     scl_s;
  logic                     scl_d;
  logic                     sda_m;
  logic                     sda_s;
  logic                     sda_d;
  logic                     wp_m;
  logic                     wp_s;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_c;
  logic                     stop_c;
  seb_pkg::seb_state_e      state;
  logic [3:0]               bit_cnt;
  logic [7:0]               rx_sh;
  logic [7:0]               tx_sh;
  logic                     m_ack;
  logic                     byte_done;
  logic                     slot_end;
  logic                     ctrl_ok;
  logic                     ack_now;
  logic                     tx_load;
  logic                     read_nack;
  logic [ADDR_W-1:0]        addr_ptr;
  logic [7:0]               page_buf [PAGE_N];
  logic [PAGE_N-1:0]        page_vld;
  logic                     prog_go;
  logic [HI_W-1:0]          prog_hi;
  logic [PAGE_W:0]          prog_idx;
  logic [TMR_W-1:0]         prog_tmr;
  logic [PAGE_W-1:0]        walk_pos;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // two-stage synchronisers plus one history stage for edge finding
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      wp_m  <= 1'b0;
      wp_s  <= 1'b0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      wp_m  <= wp_in;
      wp_s  <= wp_m;
    end
  end

  // bus conditions from synchronised levels
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // byte slot decode
  assign byte_done = scl_fall && (bit_cnt == seb_pkg::CNT_ACK);
  assign slot_end  = scl_fall && (bit_cnt == seb_pkg::CNT_END);
  assign ctrl_ok   = (state == seb_pkg::ST_CTRL) && ctrl_match(rx_sh) && !prog_busy;
  assign ack_now   = ctrl_ok || (state == seb_pkg::ST_WADDR) || (state == seb_pkg::ST_WDATA);
  assign tx_load   = slot_end && (state == seb_pkg::ST_READ) && m_ack;
  assign read_nack = slot_end && (state == seb_pkg::ST_READ) && !m_ack;
  assign walk_pos  = prog_idx[PAGE_W-1:0];

  // bit counter: eight data clocks then the acknowledge clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= seb_pkg::CNT_ZERO;
    end else if (start_c || stop_c) begin
      bit_cnt <= seb_pkg::CNT_ZERO;
    end else if (scl_rise && (bit_cnt != seb_pkg::CNT_END)) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (slot_end) begin
      bit_cnt <= seb_pkg::CNT_ZERO;
    end
  end

  // receive shifter and master acknowledge sample on rising clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_sh <= 8'h00;
      m_ack <= 1'b0;
    end else if (scl_rise && (bit_cnt < seb_pkg::CNT_ACK)) begin
      rx_sh <= {rx_sh[6:0], sda_s};
    end else if (scl_rise && (bit_cnt == seb_pkg::CNT_ACK)) begin
      m_ack <= ~sda_s;
    end
  end

  // transaction state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= seb_pkg::ST_IDLE;
    end else if (start_c) begin
      state <= seb_pkg::ST_CTRL;
    end else if (stop_c) begin
      state <= seb_pkg::ST_IDLE;
    end else if (byte_done) begin
      unique case (state)
        seb_pkg::ST_CTRL: begin
          if (!ctrl_ok) begin
            state <= seb_pkg::ST_IGNORE;
          end else if (rx_sh[seb_pkg::RW_BIT]) begin
            state <= seb_pkg::ST_READ;
          end else begin
            state <= seb_pkg::ST_WADDR;
          end
        end
        seb_pkg::ST_WADDR:  state <= seb_pkg::ST_WDATA;
        seb_pkg::ST_IDLE:   state <= seb_pkg::ST_IDLE;
        seb_pkg::ST_WDATA:  state <= seb_pkg::ST_WDATA;
        seb_pkg::ST_READ:   state <= seb_pkg::ST_READ;
        seb_pkg::ST_IGNORE: state <= seb_pkg::ST_IGNORE;
      endcase
    end else if (read_nack) begin
      state <= seb_pkg::ST_IGNORE;
    end
  end

  // address pointer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_ptr <= '0;
    end else if (byte_done && ctrl_ok) begin
      addr_ptr[ADDR_W-1 -: seb_pkg::BLK_W] <= rx_sh[seb_pkg::BLK_LSB +: seb_pkg::BLK_W];
    end else if (byte_done && (state == seb_pkg::ST_WADDR)) begin
      addr_ptr[seb_pkg::BYTE_W-1:0] <= rx_sh;
    end else if (byte_done && (state == seb_pkg::ST_WDATA)) begin
      addr_ptr[PAGE_W-1:0] <= addr_ptr[PAGE_W-1:0] + PAGE_W'(1);
    end else if (tx_load) begin
      addr_ptr <= addr_ptr + ADDR_W'(1);
    end
  end

  // page buffer data, slot picked by the low pointer bits
  always_ff @(posedge clk_sys) begin
    if (byte_done && (state == seb_pkg::ST_WDATA)) begin
      page_buf[addr_ptr[PAGE_W-1:0]] <= rx_sh;
    end
  end

  // page buffer occupancy
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      page_vld <= '0;
    end else if (byte_done && (state == seb_pkg::ST_WADDR)) begin
      page_vld <= '0;
    end else if (byte_done && (state == seb_pkg::ST_WDATA)) begin
      page_vld[addr_ptr[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // open-drain data drive: ack slots and read bits, changed only after scl falls
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_oe <= 1'b0;
      tx_sh  <= 8'h00;
    end else if (start_c || stop_c) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      sda_oe <= ack_now;
    end else if (tx_load) begin
      sda_oe <= ~mem_rdata[7];
      tx_sh  <= {mem_rdata[6:0], 1'b0};
    end else if (slot_end) begin
      sda_oe <= 1'b0;
    end else if (scl_fall && (state == seb_pkg::ST_READ) && (bit_cnt < seb_pkg::CNT_ACK)) begin
      sda_oe <= ~tx_sh[7];
      tx_sh  <= {tx_sh[6:0], 1'b0};
    end
  end

  // the pad only ever pulls low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // read address follows the pointer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_raddr <= '0;
    end else begin
      mem_raddr <= addr_ptr;
    end
  end

  // programming request on stop after buffered data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_go <= 1'b0;
    end else begin
      prog_go <= stop_c && (state == seb_pkg::ST_WDATA) && (|page_vld) && !wp_s && !prog_busy;
    end
  end

  // programming engine: walk the buffer while the write-time counter runs from the request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_busy <= 1'b0;
      prog_idx  <= '0;
      prog_tmr  <= '0;
      prog_hi   <= '0;
    end else if (prog_go) begin
      prog_busy <= 1'b1;
      prog_idx  <= '0;
      prog_tmr  <= '0;
      prog_hi   <= addr_ptr[ADDR_W-1:PAGE_W];
    end else if (prog_busy) begin
      if (!prog_idx[PAGE_W]) begin
        prog_idx <= prog_idx + (PAGE_W + 1)'(1);
      end
      prog_tmr <= prog_tmr + TMR_W'(1);
      if (prog_tmr == TMR_LAST) begin
        prog_busy <= 1'b0;
      end
    end
  end

  // array write port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= 8'h00;
    end else begin
      mem_we    <= prog_busy && !prog_idx[PAGE_W] && page_vld[walk_pos] && !wp_s;
      mem_waddr <= {prog_hi, walk_pos};
      mem_wdata <= page_buf[walk_pos];
    end
  end

  // a start always reopens the control byte phase
  AST_START_REOPENS: assert property (start_c |=> (state == seb_pkg::ST_CTRL) && (bit_cnt == seb_pkg::CNT_ZERO))
    else $error("start did not reopen the control phase");

  // a stop returns to idle with data released
  AST_STOP_IDLE: assert property (stop_c |=> (state == seb_pkg::ST_IDLE) && !sda_oe)
    else $error("stop did not return to idle");

  // foreign code: silent and ignoring
  AST_FOREIGN_CODE: assert property (byte_done && (state == seb_pkg::ST_CTRL) && !ctrl_match(rx_sh)
                                     |=> (state == seb_pkg::ST_IGNORE) && !sda_oe)
    else $error("foreign type code was acknowledged");

  // no acknowledge to a control byte while busy
  AST_BUSY_SILENT: assert property (byte_done && (state == seb_pkg::ST_CTRL) && prog_busy |=> !sda_oe)
    else $error("acknowledge given during programming");

  // acknowledge, except to a read control byte, still driven when the ninth clock rises and for two cycles on
  AST_ACK_HELD: assert property (scl_rise && (bit_cnt == seb_pkg::CNT_ACK) && sda_oe
                                 && (state != seb_pkg::ST_READ) |-> ##1 sda_oe ##1 sda_oe)
    else $error("acknowledge dropped during clock high");

  // data byte moves only the low pointer bits
  AST_PAGE_WRAP: assert property (byte_done && (state == seb_pkg::ST_WDATA)
                                  |=> (addr_ptr[ADDR_W-1:PAGE_W] == $past(addr_ptr[ADDR_W-1:PAGE_W]))
                                  && (addr_ptr[PAGE_W-1:0] == $past(addr_ptr[PAGE_W-1:0]) + PAGE_W'(1)))
    else $error("page write pointer moved outside the page");

  // each read byte advances the whole pointer by one
  AST_READ_INC: assert property (tx_load |=> addr_ptr == $past(addr_ptr) + ADDR_W'(1))
    else $error("read pointer did not advance by one");

  // stop after only the word address never starts programming
  AST_ADDR_ONLY: assert property (stop_c && (state == seb_pkg::ST_WDATA) && !(|page_vld) && !prog_busy |-> ##2 !prog_busy)
    else $error("programming started without data");

  // protected device never programs
  AST_PROTECT: assert property (wp_s && $past(wp_s) |-> !mem_we)
    else $error("array written while protected");

  // nack releases the line and ends the read
  AST_NACK_RELEASE: assert property (read_nack |=> !sda_oe && (state == seb_pkg::ST_IGNORE))
    else $error("line not released after master nack");

endmodule : seb_slave

// file: test/seb_mst.sv
// two-wire bus master model that drives clock and data towards the slave
`timescale 1ns/1ps
module seb_mst (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // one quarter of the 800 ns bus clock period
  task automatic qtr();
    repeat (2) @(posedge clk_sys);
  endtask : qtr
  // start, also used as repeated start
  task automatic start();
    sda_pull <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  task automatic stop();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b0;
    qtr();
    qtr();
  endtask : stop
  // data set in the low phase, wire read twice while clock high
  task automatic clk_bit(input logic b, output logic mid, output logic late);
    sda_pull <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    mid = sda_line;
    qtr();
    late = sda_line;
    scl  <= 1'b0;
    qtr();
  endtask : clk_bit
  // byte out, ack must stay low over the whole ninth high time
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic m, l;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], m, l);
    end
    clk_bit(1'b1, m, l);
    ack = ~m & ~l;
  endtask : wbyte
  // byte in, then ack for more or nack to end
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic m, l;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, m, l);
      d[i] = l;
    end
    clk_bit(~more, m, l);
  endtask : rbyte
endmodule : seb_mst

// file: test/test_seb_slave.sv
// self-checking bench of the serial eeprom bus slave
`timescale 1ns/1ps
module test_seb_slave;
  localparam int TWR = 200;
  logic        clk_sys, resetn, scl, sda_pull, sda_out, sda_oe, wp_in, mem_we, prog_busy, busy_seen;
  logic [10:0] mem_raddr, mem_waddr, a;
  logic [7:0]  mem_rdata, mem_wdata;
  logic [7:0]  mem [2048];
  logic [7:0]  exp [2048];
  logic [31:0] seed;
  logic        ack;
  int          fail_count, compares, cyc, n, diffs;
  wire         sda_line;
  // open-drain wire with pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

  seb_slave #(.TWR_CYCLES(TWR)) seb_slave_inst (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_in(wp_in), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_busy(prog_busy)
  );
  seb_mst seb_mst_inst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // array model, busy watcher and hang guard
  always @(posedge clk_sys) begin
    mem_rdata <= mem[mem_raddr];
    if (mem_we === 1'b1) begin
      mem[mem_waddr] <= mem_wdata;
    end
    if (prog_busy === 1'b1) begin
      busy_seen <= 1'b1;
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // page slot reached k bytes after address a
  function automatic logic [10:0] slot(input logic [10:0] a, input int k);
    return {a[10:4], a[3:0] + k[3:0]};
  endfunction : slot
  task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  // control byte and word address, no stop
  task automatic seta(input logic [10:0] a);
    seb_mst_inst.start();
    seb_mst_inst.wbyte({4'hA, a[10:8], 1'b0}, ack);
    chk("ctrl ack", 1, ack);
    seb_mst_inst.wbyte(a[7:0], ack);
    chk("addr ack", 1, ack);
  endtask : seta
  // write n random bytes from a, then poll until acknowledged
  task automatic wr(input logic [10:0] a, input int n, input logic prog);
    logic [7:0] d;
    int         polls;
    seta(a);
    for (int k = 0; k < n; k++) begin
      seed = xs(seed);
      d    = seed[7:0];
      seb_mst_inst.wbyte(d, ack);
      chk("data ack", 1, ack);
      if (prog) begin
        exp[slot(a, k)] = d;
      end
    end
    busy_seen = 1'b0;
    seb_mst_inst.stop();
    polls = 0;
    do begin
      seb_mst_inst.start();
      seb_mst_inst.wbyte(8'hA0, ack);
      seb_mst_inst.stop();
      polls++;
    end while (ack !== 1'b1 && polls < 30);
    chk("poll ack", 1, ack);
    chk("busy seen", prog, busy_seen);
    chk("refused polls", prog, polls > 1);
    for (int k = 0; k < 16; k++) begin
      chk("array byte", exp[slot(a, k)], mem[slot(a, k)]);
    end
  endtask : wr
  // read n bytes starting at the pointer, expected at a
  task automatic rd(input logic [10:0] a, input int n);
    logic [7:0] d;
    seb_mst_inst.start();
    seb_mst_inst.wbyte({4'hA, a[10:8], 1'b1}, ack);
    chk("read ctrl ack", 1, ack);
    for (int k = 0; k < n; k++) begin
      seb_mst_inst.rbyte(k < n - 1, d);
      chk("read byte", exp[a + k[10:0]], d);
    end
    seb_mst_inst.stop();
  endtask : rd
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    resetn     = 1'b0;
    wp_in      = 1'b0;
    mem_rdata  = 8'h00;
    busy_seen  = 1'b0;
    seed       = 32'h7CFE;
    fail_count = 0;
    compares   = 0;
    cyc        = 0;
    for (int i = 0; i < 2048; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
      exp[i] = mem[i];
    end
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk("oe after reset", 0, sda_oe);
    chk("busy after reset", 0, prog_busy);
    repeat (4) @(posedge clk_sys);
    // foreign type code: no ack on it nor on what follows
    seb_mst_inst.start();
    seb_mst_inst.wbyte(8'h50, ack);
    chk("foreign ack", 0, ack);
    seb_mst_inst.wbyte(8'hA0, ack);
    chk("ignored ack", 0, ack);
    seb_mst_inst.stop();
    // every block once: overflow, full page, address only, protected
    for (int b = 0; b < 8; b++) begin
      seed = xs(seed);
      a    = {b[2:0], seed[15:8]};
      n    = (b == 1) ? 18 : (b == 2) ? 16 : (b == 3) ? 0 : 1 + int'(seed[1:0]);
      wp_in <= (b == 5);
      wr(a, n, n > 0 && b != 5);
      wp_in <= 1'b0;
      rd(slot(a, n), 1);
      seta(a);
      rd(a, 2);
    end
    // sequential read across a block boundary
    seta(11'h2FF);
    rd(11'h2FF, 3);
    diffs = 0;
    for (int i = 0; i < 2048; i++) begin
      if (mem[i] !== exp[i]) begin
        diffs++;
      end
    end
    chk("array diffs", 0, diffs != 0);
    summarize();
  end
endmodule : test_seb_slave
